// ### src/fcp_pkg.sv
// Constants and carrier types of the flash control and boot protection block
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus
package fcp_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0]  FCP_UNLOCK_IDX = 10'h0EE;
  localparam logic [9:0]  FCP_CTRL_IDX   = 10'h0EF;
  localparam logic [9:0]  FCP_STATUS_IDX = 10'h0F0;

  // ==========================================================
  // Register fields and reset values
  localparam logic [7:0]  FCP_UNLOCK_RST = 8'h00;
  localparam logic [7:0]  FCP_UNLOCK_KEY = 8'hA5;
  localparam logic [3:0]  FCP_MODE_RST   = 4'h0;
  localparam int          FCP_MODE_LSB   = 4;
  localparam int          FCP_START_BIT  = 0;
  localparam logic [3:0]  FCP_MODE_PROG  = 4'h5;
  localparam logic [3:0]  FCP_MODE_LOCK  = 4'h6;
  localparam logic [3:0]  FCP_MODE_ERASE = 4'hA;

  // ==========================================================
  // Option byte fields and address decode
  localparam int          FCP_OPT_VOFF   = 7;
  localparam int          FCP_OPT_VSEL   = 5;
  localparam int          FCP_OPT_ROFF   = 2;
  localparam logic [15:0] FCP_VEC_PLAIN  = 16'h0100;
  localparam logic [15:0] FCP_REG_BASE   = 16'h0100;
  localparam logic [15:0] FCP_VEC_TBL [4] =
    '{16'h0200, 16'h0300, 16'h0500, 16'h0900};
  localparam logic [15:0] FCP_TOP_TBL [4] =
    '{16'h01FF, 16'h02FF, 16'h04FF, 16'h08FF};

  // ==========================================================
  // Timing
  localparam int          FCP_ERASE_MS   = 10;
  localparam int          FCP_CLK_KHZ    = 100_000;
  localparam int          FCP_ERASE_CYC  = FCP_ERASE_MS * FCP_CLK_KHZ;

  // ==========================================================
  // Types
  typedef enum logic {PH_IDLE, PH_ERASE} fcp_phase_t;

  typedef struct packed {
    logic        valid;
    logic        prog;
    logic [15:0] addr;
  } fcp_load_t;

  typedef struct packed {
    fcp_phase_t  phase;
    logic [31:0] cnt;
    logic [3:0]  mode;
    logic        start;
    logic [7:0]  unlock;
    logic [7:0]  opt;
    logic        opt_done;
    logic        wr_pend;
    logic [9:0]  wr_idx;
    logic [31:0] rdata;
    logic        go_erase;
    logic        go_lock;
    logic        go_prog;
    logic        blocked;
    logic        refused;
  } fcp_state_t;

endpackage

// ### src/fcp_flash_ctrl.sv
// Flash operation control with boot region protection and vector select
// Assumes AHB-Lite single slave, option byte stable around reset release
//
// Behaviour
// RULE_01 - Block load program or erase inside an enabled boot region.
// RULE_02 - Boot region exists only when the option region bit is 0.
// RULE_03 - Tool programming mode bypasses boot region protection.
// RULE_04 - Reset vector chosen by option bits 7..5.
// RULE_05 - Boot region size chosen by option bits 2..0.
// RULE_06 - Vector field and size field decode independently.
// RULE_07 - Control register writes act only in user program mode.
// RULE_08 - Mode field codes 5, 6, A valid; other codes start nothing.
// RULE_09 - Software writes zero to control bits 3..1.
// RULE_10 - Start bit launches erase or hard lock.
// RULE_11 - Erase stalls the CPU for 10 ms, then releases it.
// RULE_12 - Byte program and read need no start bit.
// RULE_13 - User program mode only while unlock register holds A5h.
// RULE_14 - Software unlocks, sets sector, writes A1h, then relocks.
// RULE_15 - Start bit self-clears on completion; mode and start reset to zero.
`timescale 1ns/1ps

module fcp_flash_ctrl
  import fcp_pkg::*;
#(
  parameter int ERASE_CYC = FCP_ERASE_CYC
) (
  input  wire logic        hclk,         // System clock
  input  wire logic        hresetn,      // Async reset, active low
  input  wire logic        ce,           // Clock enable
  input  wire logic        hsel,         // Slave select
  input  wire logic [31:0] haddr,        // Byte address
  input  wire logic [1:0]  htrans,       // Transfer type
  input  wire logic        hwrite,       // Write access
  input  wire logic [2:0]  hsize,        // Transfer size
  input  wire logic [31:0] hwdata,       // Write data
  input  wire logic        hready,       // Bus ready
  output logic             hreadyout,    // Slave ready
  output logic             hresp,        // Always OKAY
  output logic      [31:0] hrdata,       // Read data
  input  wire logic [7:0]  option_byte,  // Nonvolatile option byte
  input  wire logic        tool_mode,    // Serial tool programming
  input  wire fcp_load_t   load_req,     // Load-instruction request
  input  wire logic [15:0] sector_addr,  // Sector base for erase
  output logic             cpu_stall,    // CPU held during erase
  output logic             erase_go,     // Erase launched pulse
  output logic             lock_go,      // Hard lock pulse
  output logic             prog_go,      // Byte program accepted
  output logic             load_blocked, // Program refused pulse
  output logic             region_en,    // Boot region active
  output logic      [15:0] region_top,   // Last protected address
  output logic      [15:0] reset_vector  // Vector after power-on
);

  // ==========================================================
  // Parameter check
  if (ERASE_CYC < 1) begin : g_bad
    $error("ERASE_CYC must be at least one");
  end

  localparam logic [31:0] ERASE_LAST = 32'(ERASE_CYC - 1);

  fcp_state_t st;
  fcp_state_t next_st;

  logic       upm;
  logic       ph_ok;
  logic       mapped;
  logic       in_reg;
  logic       sec_reg;
  logic       prot;
  logic       mode_ok;

  // ==========================================================
  // Option decode
  assign upm          = (st.unlock == FCP_UNLOCK_KEY); // [RULE_13]
  assign region_en    = !st.opt[FCP_OPT_ROFF];          // [RULE_02]
  assign region_top   = FCP_TOP_TBL[st.opt[1:0]];       // [RULE_05] [RULE_06]
  assign reset_vector = st.opt[FCP_OPT_VOFF] ? FCP_VEC_PLAIN
                      : FCP_VEC_TBL[st.opt[6:5]];       // [RULE_04] [RULE_06]

  assign in_reg  = region_en && load_req.addr >= FCP_REG_BASE
                && load_req.addr <= region_top;
  assign sec_reg = region_en && sector_addr >= FCP_REG_BASE
                && sector_addr <= region_top;
  assign prot    = in_reg && !tool_mode;                // [RULE_01] [RULE_03]

  // ==========================================================
  // Bus decode
  assign ph_ok   = hsel && htrans[1] && hready;
  assign mapped  = (haddr[31:12] == 20'h0_0000);
  assign mode_ok = (hwdata[7:4] == FCP_MODE_ERASE)
                || (hwdata[7:4] == FCP_MODE_LOCK);      // [RULE_08]

  // ==========================================================
  // Next state
  always_comb begin
    next_st          = st;
    next_st.go_erase = 1'b0;
    next_st.go_lock  = 1'b0;
    next_st.go_prog  = 1'b0;
    next_st.blocked  = 1'b0;

    if (!st.opt_done) begin
      next_st.opt      = option_byte;
      next_st.opt_done = 1'b1;
    end

    // Data phase of a write
    if (st.wr_pend) begin
      if (st.wr_idx == FCP_UNLOCK_IDX) begin
        next_st.unlock = hwdata[7:0];                   // [RULE_13]
      end
      if (st.wr_idx == FCP_CTRL_IDX && upm
          && st.phase == PH_IDLE && !st.start) begin    // [RULE_07]
        next_st.mode  = hwdata[7:FCP_MODE_LSB];
        next_st.start = hwdata[FCP_START_BIT] && mode_ok; // [RULE_10]
      end
    end

    // Operation sequencing
    unique case (st.phase)
      PH_IDLE: begin
        if (st.start && st.mode == FCP_MODE_ERASE) begin
          if (sec_reg && !tool_mode) begin
            next_st.start   = 1'b0;                     // [RULE_01]
            next_st.refused = 1'b1;
          end else begin
            next_st.phase    = PH_ERASE;                // [RULE_11]
            next_st.cnt      = ERASE_LAST;
            next_st.go_erase = 1'b1;
            next_st.refused  = 1'b0;
          end
        end else if (st.start) begin
          next_st.go_lock = 1'b1;                       // [RULE_10]
          next_st.start   = 1'b0;                       // [RULE_15]
        end
      end
      PH_ERASE: begin
        if (st.cnt == 32'h0000_0000) begin
          next_st.phase = PH_IDLE;                      // [RULE_11]
          next_st.start = 1'b0;                         // [RULE_15]
        end else begin
          next_st.cnt = st.cnt - 32'h0000_0001;
        end
      end
    endcase

    // Byte program through the load instruction
    if (load_req.valid && load_req.prog) begin
      if (prot) begin
        next_st.blocked = 1'b1;                         // [RULE_01]
      end else if (upm && st.mode == FCP_MODE_PROG
                   && st.phase == PH_IDLE) begin
        next_st.go_prog = 1'b1;                         // [RULE_12]
      end
    end

    // Address phase
    next_st.wr_pend = ph_ok && hwrite && mapped;
    next_st.wr_idx  = haddr[11:2];
    if (ph_ok && !hwrite) begin
      next_st.rdata = 32'h0000_0000;
      if (mapped) begin
        unique case (haddr[11:2])
          FCP_CTRL_IDX:
            next_st.rdata[7:0] = {st.mode, 3'b000, st.start};
          FCP_UNLOCK_IDX:
            next_st.rdata[7:0] = st.unlock;
          FCP_STATUS_IDX:
            next_st.rdata[15:0] = {st.opt, 4'h0, region_en,
                                   st.refused, cpu_stall, upm};
          default:
            next_st.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st        <= '0;
      st.phase  <= PH_IDLE;
      st.mode   <= FCP_MODE_RST;                        // [RULE_15]
      st.unlock <= FCP_UNLOCK_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout   = ce;
  assign hresp       = 1'b0;
  assign hrdata      = st.rdata;
  assign cpu_stall   = (st.phase == PH_ERASE);
  assign erase_go    = st.go_erase;
  assign lock_go     = st.go_lock;
  assign prog_go     = st.go_prog;
  assign load_blocked = st.blocked;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_erase_stall: assert property ( // [RULE_11]
    erase_go |-> cpu_stall && st.cnt == ERASE_LAST)
    else $error("erase launched without stall");

  chk_stall_end: assert property ( // [RULE_15]
    ce && cpu_stall && st.cnt == 32'h0000_0000
    |=> !cpu_stall && !st.start)
    else $error("erase end did not release");

  chk_stall_hold: assert property ( // [RULE_11]
    ce && cpu_stall && st.cnt != 32'h0000_0000 |=> cpu_stall)
    else $error("stall dropped early");

  chk_lock_pulse: assert property ( // [RULE_10]
    lock_go |-> st.mode == FCP_MODE_LOCK && !st.start && !cpu_stall)
    else $error("hard lock pulse without lock mode");

  chk_ctrl_locked: assert property ( // [RULE_07]
    ce && st.wr_pend && st.wr_idx == FCP_CTRL_IDX && !upm
    |=> $stable(st.mode) && !$rose(st.start))
    else $error("control changed while locked");

  chk_unlock_key: assert property ( // [RULE_13]
    ce && st.wr_pend && st.wr_idx == FCP_UNLOCK_IDX
    && hwdata[7:0] != FCP_UNLOCK_KEY |=> !upm)
    else $error("user mode without key");

  chk_region_block: assert property ( // [RULE_01]
    ce && load_req.valid && load_req.prog && in_reg && !tool_mode
    |=> load_blocked && !prog_go)
    else $error("program inside boot region not blocked");

  chk_tool_bypass: assert property ( // [RULE_03]
    ce && load_req.valid && load_req.prog && tool_mode && upm
    && st.mode == FCP_MODE_PROG && !cpu_stall |=> prog_go)
    else $error("tool mode program refused");

  chk_region_off: assert property ( // [RULE_02]
    st.opt[FCP_OPT_ROFF] |-> !region_en && !sec_reg)
    else $error("region active while disabled");

  chk_field_indep: assert property ( // [RULE_06]
    $stable(st.opt[7:5]) |-> $stable(reset_vector))
    else $error("size field moved the vector");

  chk_start_valid: assert property ( // [RULE_08]
    st.start |-> st.mode == FCP_MODE_ERASE
              || st.mode == FCP_MODE_LOCK)
    else $error("start with reserved mode");


  // ==========================================================
  // Checks: register access

  chk_ctrl_write: assert property ( // [RULE_07]
    ce && st.wr_pend && st.wr_idx == FCP_CTRL_IDX && upm
    && !cpu_stall && !st.start |=> st.mode == $past(hwdata[7:4]))
    else $error("control write in user mode lost");

  chk_erase_busy: assert property ( // [RULE_07]
    ce && cpu_stall && st.wr_pend && st.wr_idx == FCP_CTRL_IDX
    |=> $stable(st.mode))
    else $error("mode changed during erase");

  chk_unlock_open: assert property ( // [RULE_13]
    ce && st.wr_pend && st.wr_idx == FCP_UNLOCK_IDX
    && hwdata[7:0] == FCP_UNLOCK_KEY |=> upm)
    else $error("key did not open user mode");

  chk_prog_locked: assert property ( // [RULE_13]
    ce && load_req.valid && load_req.prog && !upm
    |=> !prog_go)
    else $error("program accepted outside user mode");

  chk_reserved_code: assert property ( // [RULE_08]
    ce && st.wr_pend && st.wr_idx == FCP_CTRL_IDX && upm
    && !cpu_stall && !st.start && !mode_ok |=> !st.start)
    else $error("reserved code set the start bit");

  // ==========================================================
  // Checks: option decode and sequencing

  chk_vector_plain: assert property ( // [RULE_04]
    st.opt[FCP_OPT_VOFF] |-> reset_vector == FCP_VEC_PLAIN)
    else $error("plain vector not chosen");

  chk_vector_table: assert property ( // [RULE_04]
    !st.opt[FCP_OPT_VOFF]
    |-> reset_vector[7:0] == 8'h00 && reset_vector != FCP_VEC_PLAIN)
    else $error("boot vector out of table");

  chk_size_code: assert property ( // [RULE_05]
    region_en |-> region_top[7:0] == 8'hFF
               && region_top <= 16'h08FF)
    else $error("region top out of range");

  chk_region_free: assert property ( // [RULE_02]
    ce && load_req.valid && load_req.prog && st.opt[FCP_OPT_ROFF]
    && upm && st.mode == FCP_MODE_PROG && !cpu_stall
    |=> prog_go && !load_blocked)
    else $error("program refused with region off");

  chk_stall_rise: assert property ( // [RULE_11]
    $rose(cpu_stall) |-> erase_go)
    else $error("stall without erase launch");

  chk_refuse_erase: assert property ( // [RULE_01]
    ce && !cpu_stall && st.start && st.mode == FCP_MODE_ERASE
    && sec_reg && !tool_mode |=> !cpu_stall && st.refused && !erase_go)
    else $error("erase of boot region not refused");

  chk_out_region: assert property ( // [RULE_01]
    ce && load_req.valid && load_req.prog && !in_reg
    |=> !load_blocked)
    else $error("program outside region blocked");

  chk_tool_erase: assert property ( // [RULE_03]
    ce && !cpu_stall && st.start && st.mode == FCP_MODE_ERASE
    && tool_mode |=> cpu_stall && erase_go)
    else $error("tool mode erase refused");

  chk_lock_launch: assert property ( // [RULE_10]
    ce && !cpu_stall && st.start && st.mode == FCP_MODE_LOCK
    |=> lock_go && !st.start)
    else $error("hard lock not launched");

  chk_erase_launch: assert property ( // [RULE_10]
    ce && !cpu_stall && st.start && st.mode == FCP_MODE_ERASE
    && !sec_reg |=> erase_go && cpu_stall)
    else $error("erase not launched");

  cov_erase: cover property (erase_go ##1 cpu_stall);
  cov_lock: cover property (lock_go);
  cov_block: cover property (load_blocked);
  cov_refuse: cover property (ce && st.refused && !cpu_stall);
  cov_prog: cover property (prog_go);

endmodule // fcp_flash_ctrl

// ### verif/tb_top.sv
// Self-checking bench for the flash control and boot protection block
// Assumes fcp_pkg and fcp_flash_ctrl are compiled first
`timescale 1ns/1ps

module tb_top;
  import fcp_pkg::*;

  localparam int EC = 20;
  localparam logic [31:0] UNL = 32'h0000_03B8;
  localparam logic [31:0] CTL = 32'h0000_03BC;
  localparam logic [31:0] STA = 32'h0000_03C0;

  logic        hclk, hresetn, hsel, hwrite, tool_mode;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0]  option_byte, ob;
  logic [15:0] sector_addr, region_top, reset_vector, a;
  logic        hreadyout, cpu_stall, erase_go, lock_go, prog_go;
  logic        load_blocked, region_en, p, hresp, ce;
  fcp_load_t   load_req;
  int          errors, checked;
  logic [15:0] vt [4] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900};
  logic [15:0] tt [4] = '{16'h01FF, 16'h02FF, 16'h04FF, 16'h08FF};
  logic [15:0] at [4] = '{16'h00FF, 16'h0100, 16'h02FF, 16'h0300};

  fcp_flash_ctrl #(.ERASE_CYC(EC)) fcp_flash_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .option_byte(option_byte),
    .tool_mode(tool_mode), .load_req(load_req), .sector_addr(sector_addr),
    .cpu_stall(cpu_stall), .erase_go(erase_go), .lock_go(lock_go),
    .prog_go(prog_go), .load_blocked(load_blocked), .region_en(region_en),
    .region_top(region_top), .reset_vector(reset_vector));

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Bus master and helpers
  task automatic bus(input logic w, input logic [31:0] ad,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= ad;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [31:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0000_0000);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic rst(input logic [7:0] o);
    hresetn     <= 1'b0;
    option_byte <= o;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
  endtask

  // Count stall cycles and launch pulses after a control write
  task automatic op(input logic [7:0] d, input int es, input int ee,
                    input int el);
    logic [7:0] s, e, l;
    s = 0;
    e = 0;
    l = 0;
    bus(1'b1, CTL, {24'h0, d});
    repeat (EC + 10) begin
      @(posedge hclk);
      #1;
      s = s + cpu_stall;
      e = e + erase_go;
      l = l + lock_go;
    end
    chk(s, es);
    chk(e, ee);
    chk(l, el);
  endtask

  function automatic logic prot(input logic [15:0] ad);
    return !option_byte[2] && ad >= 16'h0100 && ad <= tt[option_byte[1:0]]
           && !tool_mode;
  endfunction

  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    #100_000;
    errors++;
    $display("watchdog expired");
    conclude;
  end

  initial begin
    {hresetn, hsel, hwrite, tool_mode, htrans} = '0;
    {haddr, hwdata, option_byte, sector_addr} = '0;
    load_req = '0;
    ce = 1'b1;
    r = $urandom(78);
    for (int i = 0; i < 8; i++) begin
      ob = $urandom;
      ob[7:5] = i[2:0];
      ob[2:0] = ~i[2:0];
      rst(ob);
      chk(reset_vector, ob[7] ? 16'h0100 : vt[ob[6:5]]);
      chk(region_en, !ob[2]);
      if (!ob[2]) chk(region_top, tt[ob[1:0]]);
    end
    $display("test option decode done");
    rst(8'h01);
    bus(1'b1, CTL, 32'h0000_00A1);
    rd(CTL, 32'h0);
    bus(1'b1, UNL, 32'h0000_005A);
    bus(1'b1, CTL, 32'h0000_00A1);
    rd(CTL, 32'h0);
    bus(1'b1, UNL, 32'h0000_00A5);
    rd(UNL, 32'h0000_00A5);
    rd(32'h0000_0400, 32'h0);
    $display("test unlock done");
    sector_addr <= 16'h0800;
    for (int m = 0; m < 16; m++) begin
      op({m[3:0], 4'h1}, m == 10 ? EC : 0, m == 10, m == 6);
      rd(CTL, {24'h0, m[3:0], 4'h0});
    end
    $display("test modes done");
    sector_addr <= 16'h0180;
    op(8'hA1, 0, 0, 0);
    rd(STA, 32'h0000_010D);
    tool_mode <= 1'b1;
    op(8'hA1, EC, 1, 0);
    bus(1'b1, UNL, 32'h0000_0000);
    rd(STA, 32'h0000_0108);
    bus(1'b1, UNL, 32'h0000_00A5);
    $display("test protected erase done");
    bus(1'b1, CTL, 32'h0000_0050);
    for (int i = 0; i < 12; i++) begin
      a = i < 4 ? at[i] : 16'($urandom_range(16'h0A00));
      tool_mode <= i < 4 ? 1'b0 : 1'($urandom);
      load_req <= '{valid: 1'b1, prog: 1'b1, addr: a};
      @(posedge hclk);
      load_req <= '0;
      #1;
      p = prot(a);
      chk(prog_go, !p);
      chk(load_blocked, p);
    end
    @(posedge hclk);
    ce <= 1'b0;
    load_req <= '{valid: 1'b1, prog: 1'b1, addr: 16'h0300};
    @(posedge hclk);
    #1;
    chk(prog_go, 1'b0);
    chk(hreadyout, 1'b0);
    ce <= 1'b1;
    load_req <= '0;
    $display("test byte program done");
    conclude;
  end

endmodule // tb_top
